// ### logic/su0_pkg.sv
// Purpose: shared constants and types of serial port zero
// Assumes: 8-bit register address, 8-bit data, 50 MHz core clock
// Notes: offsets are byte addresses on the register port
package su0_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] ADDR_GIVEN_ADDRESS = 8'hA9;
  localparam logic [7:0] ADDR_ADDRESS_MASK = 8'hB9;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_STATUS = 8'hC5;
  localparam logic [7:0] ADDR_INT_STATUS = 8'hE8;
  localparam logic [7:0] ADDR_INT_MASK = 8'hE9;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_FRAMING_SELECT = 6;
  localparam int POS_TRANSMIT_ACTIVITY = 1;
  localparam int POS_RECEIVE_ACTIVITY = 0;
  localparam int POS_EV_TX_DONE = 0;
  localparam int POS_EV_RX_DONE = 1;
  localparam int POS_EV_FRAMING = 2;
  localparam int NUM_EVENTS = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_EVENTS = 3'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int MODE0_SLOW_CLKS = 12;
  localparam int MODE0_FAST_CLKS = 4;
  localparam int MODE2_SLOW_CLKS = 64;
  localparam int MODE2_FAST_CLKS = 32;
  localparam int OVERSAMPLE = 16;
  localparam logic [6:0] M0_SLOW = 7'(MODE0_SLOW_CLKS);
  localparam logic [6:0] M0_FAST = 7'(MODE0_FAST_CLKS);
  localparam logic [2:0] M2_SLOW_DIV = 3'(MODE2_SLOW_CLKS / OVERSAMPLE);
  localparam logic [2:0] M2_FAST_DIV = 3'(MODE2_FAST_CLKS / OVERSAMPLE);
  localparam logic [3:0] OS_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] OS_MID = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [3:0] M0_BITS_LAST = 4'h7;
  localparam logic [3:0] LAST_BIT_10 = 4'h9;
  localparam logic [3:0] LAST_BIT_11 = 4'hA;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_SHIFT = 4'b0001,
    MODE_ASYNC10 = 4'b0010,
    MODE_FIXED11 = 4'b0100,
    MODE_VAR11 = 4'b1000
  } su0_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_ASYNC = 3'b100
  } su0_state_e;

  typedef struct packed {
    logic mode_select_hi;
    logic mode_select_lo;
    logic multiproc_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } su0_ctrl_s;

endpackage

// ### logic/su0_uart.sv
// Purpose: serial port zero, shift mode and three asynchronous modes
// Assumes: BAUD_TICK is a one-cycle pulse at 16 times the bit rate
// Notes: transmit pin is port 3 bit 1, receive pin is port 3 bit 0
//
// The plain strobed port was left to the implementer.

// Functional notes
// RL1: mode field picks shift, 10-bit variable, 11-bit fixed, 11-bit variable.
// RL2: top control bit is high mode bit or framing flag per select bit.
// RL3: framing flag sets on bad stop bit, held until software clears; the code sets it only while the select bit is one.
// RL4: modes 2/3 with multiproc enable drop frames whose ninth bit is zero.
// RL5: mode 1 with multiproc enable drops frames lacking a valid stop bit.
// RL6: in mode 0 multiproc enable picks divide by 4, else by 12.
// RL7: reception only runs while receive enable is one.
// RL8: modes 2/3 send the software ninth bit as ninth data bit.
// RL9: received ninth bit holds ninth bit, or mode 1 stop bit.
// RL10: transmit done sets after eighth bit in mode 0, else at stop start.
// RL11: receive done sets after eighth bit in mode 0, else mid stop bit.
// RL12: buffer address reads receive buffer, writes transmit buffer.
// RL13: mask bits choose which given-address bits are compared.
// RL14: an all-zero mask accepts every incoming address.
// RL15: serial output on port 3 bit 1, input on port 3 bit 0.
// RL16: transmit activity reads one while sending, clears at transmit done.
// RL17: receive activity reads one while receiving, clears when the receiver returns to idle, frame accepted or not.
// RL18: modes 1 and 3 time bits from the external baud tick.
// RL19: mode 2 uses 32 clocks per bit when the doubling input is high.
module su0_uart (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic BAUD_TICK,
  input wire logic DOUBLE_RATE,
  output logic P31_TXD,
  input wire logic P30_RXD_IN,
  output logic P30_RXD_OUT,
  output logic P30_RXD_OE,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic su0_pkg::su0_mode_e mode_of(input logic hi,
                                                 input logic lo);
    case ({hi, lo})
      2'b00: mode_of = su0_pkg::MODE_SHIFT;
      2'b01: mode_of = su0_pkg::MODE_ASYNC10;
      2'b10: mode_of = su0_pkg::MODE_FIXED11;
      default: mode_of = su0_pkg::MODE_VAR11;
    endcase
  endfunction

  function automatic logic addr_hit(input logic [7:0] data,
                                    input logic [7:0] given,
                                    input logic [7:0] mask);
    addr_hit = ((data ^ given) & mask) == 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  su0_pkg::su0_ctrl_s ctrl;
  logic framing_error_flag;
  logic framing_select;
  logic [7:0] rx_buffer;
  logic [7:0] given_address;
  logic [7:0] address_mask;
  logic [2:0] int_status;
  logic [2:0] int_mask;
  logic transmit_activity;

  su0_pkg::su0_mode_e mode;
  wire nine_bit = mode == su0_pkg::MODE_FIXED11 ||
                  mode == su0_pkg::MODE_VAR11;
  wire [6:0] m0_period = ctrl.multiproc_enable ? su0_pkg::M0_FAST
                                               : su0_pkg::M0_SLOW; // RL6
  wire [6:0] m0_half = {1'b0, m0_period[6:1]};
  wire [3:0] last_bit = nine_bit ? su0_pkg::LAST_BIT_11
                                 : su0_pkg::LAST_BIT_10;

  wire wr_ctrl = WR && ADDR == su0_pkg::ADDR_SERIAL_CONTROL;
  wire wr_buf = WR && ADDR == su0_pkg::ADDR_SERIAL_BUFFER; // RL12
  wire wr_given = WR && ADDR == su0_pkg::ADDR_GIVEN_ADDRESS;
  wire wr_mask = WR && ADDR == su0_pkg::ADDR_ADDRESS_MASK;
  wire wr_power_control = WR && ADDR == su0_pkg::ADDR_POWER_CONTROL;
  wire wr_ist = WR && ADDR == su0_pkg::ADDR_INT_STATUS;
  wire wr_imask = WR && ADDR == su0_pkg::ADDR_INT_MASK;

  assign mode = mode_of(ctrl.mode_select_hi, ctrl.mode_select_lo); // RL1

  // ----------------------------------------------------------------
  // receive pin synchroniser
  // ----------------------------------------------------------------
  logic rxd_s1, rxd_s2, rxd_s3, rxd_level;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      rxd_s3 <= 1'b1;
      rxd_level <= 1'b1;
    end else begin
      rxd_s1 <= P30_RXD_IN; // RL15
      rxd_s2 <= rxd_s1;
      rxd_s3 <= rxd_s2;
      if (rxd_s2 == rxd_s3) begin
        rxd_level <= rxd_s3;
      end
    end
  end

  // ----------------------------------------------------------------
  // oversample tick
  // ----------------------------------------------------------------
  // mode 2 builds its own tick so that both ends share one phase logic
  logic [2:0] pre_cnt;
  wire [2:0] pre_div = DOUBLE_RATE ? su0_pkg::M2_FAST_DIV
                                   : su0_pkg::M2_SLOW_DIV; // RL19
  wire pre_wrap = pre_cnt == pre_div - 3'd1;
  wire os_tick = (mode == su0_pkg::MODE_FIXED11) ? pre_wrap
               : (mode == su0_pkg::MODE_SHIFT) ? 1'b0
               : BAUD_TICK; // RL18
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pre_cnt <= 3'd0;
    end else begin
      pre_cnt <= pre_wrap ? 3'd0 : pre_cnt + 3'd1;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  su0_pkg::su0_state_e tx_state;
  logic [10:0] tx_shift;
  logic [3:0] tx_bit;
  logic [6:0] tx_cnt;
  logic txd_async;
  wire tx_idle = tx_state == su0_pkg::ST_IDLE;
  wire tx_m0_end = tx_state == su0_pkg::ST_SHIFT &&
                   tx_cnt == m0_period - 7'd1;
  wire tx_os_end = tx_state == su0_pkg::ST_ASYNC && os_tick &&
                   tx_cnt[3:0] == su0_pkg::OS_LAST;
  wire tx_ninth = nine_bit ? ctrl.tx_ninth_bit : 1'b1; // RL8
  wire tx_done_set = (tx_m0_end && tx_bit == su0_pkg::M0_BITS_LAST) ||
                     (tx_os_end && tx_bit == last_bit - 4'd1); // RL10

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tx_state <= su0_pkg::ST_IDLE;
      tx_shift <= 11'h7FF;
      tx_bit <= 4'h0;
      tx_cnt <= 7'h00;
      txd_async <= 1'b1;
    end else begin
      case (tx_state)
        su0_pkg::ST_IDLE: begin
          tx_cnt <= 7'h00;
          tx_bit <= 4'h0;
          if (wr_buf && mode == su0_pkg::MODE_SHIFT) begin
            tx_shift <= {3'b111, WDATA};
            tx_state <= su0_pkg::ST_SHIFT;
          end else if (wr_buf) begin
            tx_shift <= {1'b1, tx_ninth, WDATA, 1'b0};
            txd_async <= 1'b0;
            tx_state <= su0_pkg::ST_ASYNC;
          end
        end
        su0_pkg::ST_SHIFT: begin
          tx_cnt <= tx_m0_end ? 7'h00 : tx_cnt + 7'd1;
          if (tx_m0_end) begin
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_bit <= tx_bit + 4'd1;
            if (tx_bit == su0_pkg::M0_BITS_LAST) begin
              tx_state <= su0_pkg::ST_IDLE;
            end
          end
        end
        su0_pkg::ST_ASYNC: begin
          if (os_tick) begin
            tx_cnt <= {3'b000, tx_cnt[3:0] + 4'd1};
          end
          if (tx_os_end) begin
            tx_shift <= {1'b1, tx_shift[10:1]};
            txd_async <= tx_shift[1];
            tx_bit <= tx_bit + 4'd1;
            if (tx_bit == last_bit) begin
              tx_state <= su0_pkg::ST_IDLE;
              txd_async <= 1'b1;
            end
          end
        end
        default: tx_state <= su0_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  su0_pkg::su0_state_e rx_state;
  logic [10:0] rx_frame;
  logic [3:0] rx_bit;
  logic [6:0] rx_cnt;
  logic rxd_prev;
  wire rx_idle = rx_state == su0_pkg::ST_IDLE;
  // shift receive waits for a cleared done flag, like a fresh request
  wire rx_m0_go = rx_idle && tx_idle && mode == su0_pkg::MODE_SHIFT &&
                  ctrl.rx_enable && !ctrl.rx_done_flag; // RL7
  wire rx_async_go = rx_idle && mode != su0_pkg::MODE_SHIFT &&
                     ctrl.rx_enable && rxd_prev && !rxd_level; // RL7
  wire rx_m0_mid = rx_state == su0_pkg::ST_SHIFT && rx_cnt == m0_half;
  wire rx_m0_end = rx_state == su0_pkg::ST_SHIFT &&
                   rx_cnt == m0_period - 7'd1;
  wire rx_mid = rx_state == su0_pkg::ST_ASYNC && os_tick &&
                rx_cnt[3:0] == su0_pkg::OS_MID;
  wire rx_os_end = rx_state == su0_pkg::ST_ASYNC && os_tick &&
                   rx_cnt[3:0] == su0_pkg::OS_LAST;
  wire rx_start_bad = rx_mid && rx_bit == 4'h0 && rxd_level;
  wire rx_stop_at = rx_mid && rx_bit == last_bit;
  wire stop_ok = rxd_level;
  wire [7:0] rx_data_async = rx_frame[8:1];
  wire rx_nine_in = rx_frame[9];
  wire accept_m1 = !ctrl.multiproc_enable || stop_ok; // RL5
  wire accept_m23 = !ctrl.multiproc_enable ||
                    (rx_nine_in &&
                     addr_hit(rx_data_async, given_address,
                              address_mask)); // RL4 RL13 RL14
  wire accept = mode == su0_pkg::MODE_ASYNC10 ? accept_m1 : accept_m23;
  wire rx_async_done = rx_stop_at && accept && !ctrl.rx_done_flag;
  wire rx_m0_done = rx_m0_end && rx_bit == su0_pkg::M0_BITS_LAST;
  wire rx_done_set = rx_m0_done || rx_async_done; // RL11
  wire fe_set = rx_stop_at && !stop_ok; // RL3

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rx_state <= su0_pkg::ST_IDLE;
      rx_frame <= 11'h000;
      rx_bit <= 4'h0;
      rx_cnt <= 7'h00;
      rxd_prev <= 1'b1;
    end else begin
      rxd_prev <= rxd_level;
      case (rx_state)
        su0_pkg::ST_IDLE: begin
          rx_cnt <= 7'h00;
          rx_bit <= 4'h0;
          if (rx_m0_go) begin
            rx_state <= su0_pkg::ST_SHIFT;
          end else if (rx_async_go) begin
            rx_state <= su0_pkg::ST_ASYNC;
          end
        end
        su0_pkg::ST_SHIFT: begin
          rx_cnt <= rx_m0_end ? 7'h00 : rx_cnt + 7'd1;
          if (rx_m0_mid) begin
            rx_frame <= {rx_frame[10:8], rxd_level, rx_frame[7:1]};
          end
          if (rx_m0_end) begin
            rx_bit <= rx_bit + 4'd1;
            if (rx_bit == su0_pkg::M0_BITS_LAST) begin
              rx_state <= su0_pkg::ST_IDLE;
            end
          end
          if (!ctrl.rx_enable) begin
            rx_state <= su0_pkg::ST_IDLE; // RL7
          end
        end
        su0_pkg::ST_ASYNC: begin
          if (os_tick) begin
            rx_cnt <= {3'b000, rx_cnt[3:0] + 4'd1};
          end
          if (rx_mid) begin
            rx_frame[rx_bit] <= rxd_level;
          end
          if (rx_os_end) begin
            rx_bit <= rx_bit + 4'd1;
          end
          // frame ends mid stop bit so a new start edge is not missed
          if (rx_start_bad || rx_stop_at || !ctrl.rx_enable) begin
            rx_state <= su0_pkg::ST_IDLE;
          end
        end
        default: rx_state <= su0_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  su0_pkg::su0_ctrl_s wctrl;
  assign wctrl = su0_pkg::su0_ctrl_s'(WDATA);
  wire [2:0] events;
  assign events[su0_pkg::POS_EV_TX_DONE] = tx_done_set;
  assign events[su0_pkg::POS_EV_RX_DONE] = rx_done_set;
  assign events[su0_pkg::POS_EV_FRAMING] = fe_set;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl <= su0_pkg::su0_ctrl_s'(su0_pkg::RST_BYTE);
      framing_error_flag <= 1'b0;
      framing_select <= 1'b0;
      rx_buffer <= su0_pkg::RST_BYTE;
      given_address <= su0_pkg::RST_BYTE;
      address_mask <= su0_pkg::RST_BYTE;
      int_status <= su0_pkg::RST_EVENTS;
      int_mask <= su0_pkg::RST_EVENTS;
      transmit_activity <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wctrl;
        if (framing_select) begin
          ctrl.mode_select_hi <= ctrl.mode_select_hi; // RL2
          framing_error_flag <= wctrl.mode_select_hi;
        end
      end
      if (fe_set && framing_select) begin
        framing_error_flag <= 1'b1; // RL3
      end
      // hardware set wins over a software clear in the same cycle
      if (tx_done_set) begin
        ctrl.tx_done_flag <= 1'b1; // RL10
      end
      if (rx_done_set) begin
        ctrl.rx_done_flag <= 1'b1; // RL11
        rx_buffer <= rx_m0_done ? rx_frame[7:0] : rx_data_async;
      end
      if (rx_async_done) begin
        ctrl.rx_ninth_bit <= nine_bit ? rx_nine_in : stop_ok; // RL9
      end
      if (wr_power_control) begin
        framing_select <= WDATA[su0_pkg::POS_FRAMING_SELECT];
      end
      if (wr_given) begin
        given_address <= WDATA;
      end
      if (wr_mask) begin
        address_mask <= WDATA;
      end
      if (wr_imask) begin
        int_mask <= WDATA[2:0];
      end
      int_status <= (int_status & ~(wr_ist ? WDATA[2:0] : 3'h0)) | events;
      if (wr_buf && tx_idle) begin
        transmit_activity <= 1'b1; // RL16
      end else if (tx_done_set) begin
        transmit_activity <= 1'b0; // RL16
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  wire [7:0] ctrl_rd = {framing_select ? framing_error_flag
                                       : ctrl.mode_select_hi,
                        7'(ctrl)}; // RL2
  wire [7:0] status_rd = {6'h00, transmit_activity,
                          !rx_idle}; // RL17
  wire [7:0] rd_mux =
      ADDR == su0_pkg::ADDR_SERIAL_CONTROL ? ctrl_rd :
      ADDR == su0_pkg::ADDR_SERIAL_BUFFER ? rx_buffer : // RL12
      ADDR == su0_pkg::ADDR_GIVEN_ADDRESS ? given_address :
      ADDR == su0_pkg::ADDR_ADDRESS_MASK ? address_mask :
      ADDR == su0_pkg::ADDR_POWER_CONTROL ?
        {1'b0, framing_select, 6'h00} :
      ADDR == su0_pkg::ADDR_STATUS ? status_rd :
      ADDR == su0_pkg::ADDR_INT_STATUS ? {5'h00, int_status} :
      ADDR == su0_pkg::ADDR_INT_MASK ? {5'h00, int_mask} : 8'h00;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= su0_pkg::RST_BYTE;
    end else begin
      RDATA <= RD ? rd_mux : su0_pkg::RST_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // pins and interrupt
  // ----------------------------------------------------------------
  // mode 0 drives the shift clock on the transmit pin, low in first half
  wire m0_clk_low = (tx_state == su0_pkg::ST_SHIFT && tx_cnt < m0_half) ||
                    (rx_state == su0_pkg::ST_SHIFT && rx_cnt < m0_half);
  assign P31_TXD = (mode == su0_pkg::MODE_SHIFT) ? !m0_clk_low
                                                 : txd_async; // RL15
  assign P30_RXD_OUT = tx_shift[0];
  assign P30_RXD_OE = tx_state == su0_pkg::ST_SHIFT; // RL15
  assign IRQ = |(int_status & int_mask);

endmodule

// ### tb/su0_assertions.sv
// Purpose: port-level checker for serial port zero
// Assumes: bench keeps >=1000 cycles between serial buffer writes
// Notes: shadows the control, mask and select registers from writes
module su0_assertions (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic BAUD_TICK,
  input wire logic DOUBLE_RATE,
  input wire logic P31_TXD,
  input wire logic P30_RXD_IN,
  input wire logic P30_RXD_OUT,
  input wire logic P30_RXD_OE,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // shadows
  // ----------------------------------------------------------------
  logic [7:0] mask_sh;
  logic [7:0] byte_sh;
  logic [1:0] mode_sh;
  logic fs_sh, tb8_sh, m2f;
  logic [10:0] since;
  logic [6:0] oe_cnt;
  wire wr_buf = WR && ADDR == su0_pkg::ADDR_SERIAL_BUFFER;
  wire quiet = since >= 11'd1000;
  // only starts from a quiet line; a busy write is ignored
  wire async_start = wr_buf && quiet && mode_sh != 2'b00;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mask_sh <= 8'h00;
      byte_sh <= 8'h00;
      mode_sh <= 2'b00;
      fs_sh <= 1'b0;
      tb8_sh <= 1'b0;
      m2f <= 1'b0;
      since <= 11'd1000;
      oe_cnt <= 7'h00;
    end else begin
      if (WR && ADDR == su0_pkg::ADDR_INT_MASK) mask_sh <= WDATA;
      if (WR && ADDR == su0_pkg::ADDR_POWER_CONTROL) fs_sh <= WDATA[6];
      if (WR && ADDR == su0_pkg::ADDR_SERIAL_CONTROL) begin
        mode_sh <= {fs_sh ? mode_sh[1] : WDATA[7], WDATA[6]};
        tb8_sh <= WDATA[3];
      end
      since <= wr_buf ? 11'h000 : (quiet ? since : since + 11'h001);
      if (wr_buf && quiet) begin
        m2f <= mode_sh == 2'b10 && DOUBLE_RATE;
        byte_sh <= WDATA;
      end
      oe_cnt <= P30_RXD_OE ? oe_cnt + 7'h01 : 7'h00;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_rd_idle;
    !$past(RD) |-> RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_irq_mask;
    mask_sh == 8'h00 && $past(mask_sh) == 8'h00 |-> !IRQ;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt while fully masked");
  property p_m0_clk;
    $rose(P30_RXD_OE) |-> ##[0:2] !P31_TXD;
  endproperty
  a_m0_clk: assert property (p_m0_clk)
    else $error("shift clock not low at shift start");
  property p_m0_len;
    $fell(P30_RXD_OE) |-> oe_cnt inside {[31:33], [95:97]};
  endproperty
  a_m0_len: assert property (p_m0_len)
    else $error("shift transfer length wrong");
  property p_m0_data;
    $rose(P31_TXD) && P30_RXD_OE |-> $stable(P30_RXD_OUT);
  endproperty
  a_m0_data: assert property (p_m0_data)
    else $error("shift data moved at clock rise");
  property p_start;
    async_start |=> !P31_TXD [*8];
  endproperty
  a_start: assert property (p_start)
    else $error("start bit missing");
  property p_data0;
    m2f && since == 11'd48 |-> P31_TXD == byte_sh[0];
  endproperty
  a_data0: assert property (p_data0)
    else $error("first data bit wrong");
  property p_ninth;
    m2f && since == 11'd304 |-> P31_TXD == tb8_sh;
  endproperty
  a_ninth: assert property (p_ninth)
    else $error("ninth bit wrong");
  property p_stop;
    m2f && since == 11'd336 |-> P31_TXD;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop bit not high");
  c_m0: cover property ($rose(P30_RXD_OE));
  c_irq: cover property ($rose(IRQ));
  c_m2: cover property (m2f && since == 11'd304);
endmodule
bind su0_uart su0_assertions su0_assertions_inst (.CLK(CLK), .NRST(NRST),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .BAUD_TICK(BAUD_TICK), .DOUBLE_RATE(DOUBLE_RATE), .P31_TXD(P31_TXD),
  .P30_RXD_IN(P30_RXD_IN), .P30_RXD_OUT(P30_RXD_OUT),
  .P30_RXD_OE(P30_RXD_OE), .IRQ(IRQ));

// ### tb/su0_remote.sv
// Purpose: remote serial device on the serial lines
// Assumes: bench calls one task at a time
// Notes: line released between frames, pull-up then reads high
module su0_remote (
  input wire logic clk,
  input wire logic txd,
  input wire logic rxd_line,
  output logic drv,
  output logic oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial drv = 1'b1;
  initial oe = 1'b0;
  // frame lsb first, start bit in bit 0
  task automatic send(input logic [10:0] f, input int n, input int cpb);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      drv <= f[i];
      oe <= 1'b1;
      repeat (cpb - 1) @(posedge clk);
    end
    @(posedge clk);
    oe <= 1'b0;
  endtask
  // samples mid-bit, so small tick phase slips are harmless
  task automatic grab(output logic [10:0] f, input int n, input int cpb);
    f = 11'h000;
    @(negedge txd);
    repeat (cpb / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (cpb) @(posedge clk);
    end
  endtask
  task automatic shift_in(output logic [7:0] b);
    b = 8'h00;
    repeat (8) begin
      @(posedge txd);
      b = {rxd_line, b[7:1]};
    end
  endtask
endmodule

// ### tb/tb_serial_port_zero_uart.sv
// Purpose: self-checking bench for serial port zero
// Assumes: baud tick every 4 clocks, so 64 clocks per variable-rate bit
// Notes: remote model drives and samples the serial lines
module tb_serial_port_zero_uart;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic BAUD_TICK = 1'b0;
  logic DOUBLE_RATE = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic [7:0] RDATA;
  logic [1:0] tdiv = 2'b00;
  logic P31_TXD, P30_RXD_OUT, P30_RXD_OE, IRQ, rem_drv, rem_oe;
  logic [7:0] d;
  logic [10:0] f;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  // pull-up wins when nobody drives
  wire rxd_line = P30_RXD_OE ? P30_RXD_OUT : (rem_oe ? rem_drv : 1'b1);
  su0_uart su0_uart_inst (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .BAUD_TICK(BAUD_TICK), .DOUBLE_RATE(DOUBLE_RATE), .P31_TXD(P31_TXD),
    .P30_RXD_IN(rxd_line), .P30_RXD_OUT(P30_RXD_OUT),
    .P30_RXD_OE(P30_RXD_OE), .IRQ(IRQ));
  su0_remote su0_remote_inst (.clk(CLK), .txd(P31_TXD),
    .rxd_line(rxd_line), .drv(rem_drv), .oe(rem_oe));
  always #10 CLK = ~CLK;
  always @(posedge CLK) begin
    tdiv <= tdiv + 2'b01;
    BAUD_TICK <= tdiv == 2'b11;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(11'(RDATA), 11'(exp));
  endtask
  task automatic wctl(input logic [7:0] v);
    wr(su0_pkg::ADDR_SERIAL_CONTROL, v);
  endtask
  // long gap keeps every write on an idle transmitter
  task automatic wbuf(input logic [7:0] v);
    repeat (1000) @(posedge CLK);
    wr(su0_pkg::ADDR_SERIAL_BUFFER, v);
  endtask
  task automatic t_regs();
    rchk(su0_pkg::ADDR_SERIAL_CONTROL, 8'h00);
    rchk(su0_pkg::ADDR_SERIAL_BUFFER, 8'h00);
    wr(su0_pkg::ADDR_ADDRESS_MASK, 8'h5A);
    rchk(su0_pkg::ADDR_ADDRESS_MASK, 8'h5A);
    wr(8'h00, 8'hFF);
    rchk(8'h00, 8'h00);
  endtask
  task automatic t_m0(input logic [7:0] c);
    wctl(c);
    wbuf(8'hA5);
    su0_remote_inst.shift_in(d);
    chk(11'(d), 11'h0A5);
    repeat (20) @(posedge CLK);
    rchk(su0_pkg::ADDR_SERIAL_CONTROL, c | 8'h02);
    rchk(su0_pkg::ADDR_STATUS, 8'h00);
    chk(11'(IRQ), 11'h000);
    wr(su0_pkg::ADDR_INT_MASK, 8'h07);
    @(posedge CLK);
    #1 chk(11'(IRQ), 11'h001);
    wr(su0_pkg::ADDR_INT_STATUS, 8'h07);
    wctl(c);
    #1 chk(11'(IRQ), 11'h000);
    wr(su0_pkg::ADDR_INT_MASK, 8'h00);
  endtask
  task automatic t_tx(input logic [7:0] c, input logic dr, input int cpb,
                      input int n, input logic [10:0] e);
    wctl(c);
    DOUBLE_RATE <= dr;
    wbuf(e[8:1]);
    fork
      su0_remote_inst.grab(f, n, cpb);
      rchk(su0_pkg::ADDR_STATUS, 8'h02);
    join
    chk(f, e);
    rchk(su0_pkg::ADDR_SERIAL_CONTROL, c | 8'h02);
    rchk(su0_pkg::ADDR_STATUS, 8'h00);
    wctl(c);
  endtask
  task automatic t_rx(input logic [7:0] c, input logic [10:0] fr,
                      input int n, input logic [7:0] ec, input logic [7:0] eb);
    wctl(c);
    su0_remote_inst.send(fr, n, n == 8 ? 12 : 64);
    repeat (20) @(posedge CLK);
    rchk(su0_pkg::ADDR_SERIAL_CONTROL, ec);
    rchk(su0_pkg::ADDR_SERIAL_BUFFER, eb);
    rchk(su0_pkg::ADDR_STATUS, 8'h00);
    wctl(c);
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    NRST <= 1'b1;
    t_regs();
    t_m0(8'h00);
    t_m0(8'h20);
    t_tx(8'h40, 1'b0, 64, 10, {2'b01, 8'h3C, 1'b0});
    t_tx(8'h88, 1'b1, 32, 11, {2'b11, 8'h96, 1'b0});
    t_tx(8'h80, 1'b0, 64, 11, {2'b10, 8'h69, 1'b0});
    t_tx(8'hC8, 1'b0, 64, 11, {2'b11, 8'h5A, 1'b0});
    t_rx(8'h50, {2'b01, 8'h6B, 1'b0}, 10, 8'h55, 8'h6B);
    t_rx(8'h40, {2'b01, 8'h11, 1'b0}, 10, 8'h40, 8'h6B);
    t_rx(8'h70, {2'b00, 8'h22, 1'b0}, 10, 8'h70, 8'h6B);
    t_rx(8'h70, {2'b01, 8'h22, 1'b0}, 10, 8'h75, 8'h22);
    wr(su0_pkg::ADDR_POWER_CONTROL, 8'h40);
    t_rx(8'h50, {2'b00, 8'h33, 1'b0}, 10, 8'hD1, 8'h33);
    rchk(su0_pkg::ADDR_SERIAL_CONTROL, 8'h50);
    wr(su0_pkg::ADDR_POWER_CONTROL, 8'h00);
    wr(su0_pkg::ADDR_ADDRESS_MASK, 8'h00);
    t_rx(8'hF0, {2'b10, 8'h44, 1'b0}, 11, 8'hF0, 8'h33);
    t_rx(8'hF0, {2'b11, 8'h44, 1'b0}, 11, 8'hF5, 8'h44);
    wr(su0_pkg::ADDR_GIVEN_ADDRESS, 8'hA0);
    wr(su0_pkg::ADDR_ADDRESS_MASK, 8'hF0);
    t_rx(8'hF0, {2'b11, 8'hA7, 1'b0}, 11, 8'hF5, 8'hA7);
    t_rx(8'hF0, {2'b11, 8'hB7, 1'b0}, 11, 8'hF0, 8'hA7);
    t_rx(8'h10, {3'b111, 8'hC3}, 8, 8'h11, 8'hC3);
    summarize();
  end
endmodule
